// >>> logic/ast_pkg.sv
// Shared constants and types of the asynchronous serial transmitter
package ast_pkg;
    // Register byte offsets
    localparam int unsigned OFF_W          = 5;
    localparam logic [4:0]  OFF_TX_CTRL    = 5'h00;
    localparam logic [4:0]  OFF_RX_CTRL    = 5'h04;
    localparam logic [4:0]  OFF_BAUD_CTRL  = 5'h08;
    localparam logic [4:0]  OFF_BAUD_DIV   = 5'h0C;
    localparam logic [4:0]  OFF_TX_HOLD    = 5'h10;
    localparam logic [4:0]  OFF_IRQ_FLAGS  = 5'h14;
    localparam logic [4:0]  OFF_IRQ_ENABLE = 5'h18;
    // Field positions
    localparam int unsigned POS_TX_ENABLE  = 0;
    localparam int unsigned POS_SYNC_SEL   = 1;
    localparam int unsigned POS_NINE_BIT   = 2;
    localparam int unsigned POS_NINTH_DATA = 3;
    localparam int unsigned POS_SHIFT_EMPT = 4;
    localparam int unsigned POS_PORT_EN    = 7;
    localparam int unsigned POS_BRG16      = 3;
    localparam int unsigned POS_POLARITY   = 4;
    localparam int unsigned POS_EMPTY_FLAG = 0;
    localparam int unsigned POS_IRQ_EN     = 0;
    // Reset values
    localparam logic [15:0] DIV_RESET      = 16'h0000;
    localparam logic [8:0]  HOLD_RESET     = 9'h000;
    // Frame lengths in bit periods, start and stop included
    localparam logic [3:0]  FRAME_BITS_8   = 4'h0A;
    localparam logic [3:0]  FRAME_BITS_9   = 4'h0B;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Software control bits
    typedef struct packed {
        logic serialPortEnable;
        logic txEnable;
        logic syncSelect;
        logic nineBit;
        logic ninthData;
        logic polarity;
        logic brg16;
        logic irqEnable;
    } ast_ctrl_t;

    localparam ast_ctrl_t CTRL_RESET = '0;

    typedef enum logic { SHIFT_IDLE, SHIFT_SEND } ast_shift_state_t;
endpackage

// >>> logic/ast_baud_gen.sv
// Bit period divider, 8-bit or 16-bit
`timescale 1ns/1ps
`default_nettype none
module ast_baud_gen #(
    parameter int unsigned DIV_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Control
    input  wire logic                 restart,
    input  wire logic                 brg16,
    input  wire logic [DIV_WIDTH-1:0] divisor,
    // Tick at the end of each bit period
    output logic                      bitTick
);
    logic [DIV_WIDTH-1:0] count_reg;
    logic [DIV_WIDTH-1:0] count_next;
    logic [DIV_WIDTH-1:0] limit;

    // Eight-bit mode uses the low byte only
    assign limit = brg16 ? divisor : {{(DIV_WIDTH-8){1'b0}}, divisor[7:0]};
    assign bitTick = (count_reg == limit);
    assign count_next = (restart || bitTick) ? '0 : count_reg + 1'b1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// >>> logic/ast_tx_shifter.sv
// Transmit shift register with frame sequencing
`timescale 1ns/1ps
`default_nettype none
module ast_tx_shifter (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clear,
    // Load from the holding buffer
    input  wire logic       load,
    input  wire logic [8:0] loadData,
    input  wire logic       nineBit,
    // Bit timing
    input  wire logic       bitTick,
    // Line and status
    output logic            lineBit,
    output logic            busy
);
    ast_pkg::ast_shift_state_t state_reg;
    logic [10:0]               shift_reg;
    logic [3:0]                bitsLeft_reg;

    assign busy    = (state_reg == ast_pkg::SHIFT_SEND);
    assign lineBit = shift_reg[0];

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            state_reg    <= ast_pkg::SHIFT_IDLE;
            shift_reg    <= '1;
            bitsLeft_reg <= '0;
        end else begin
            case (state_reg)
                ast_pkg::SHIFT_IDLE: begin
                    if (load) begin
                        // Stop, optional ninth, data LSb first, start
                        shift_reg    <= {1'b1, nineBit ? loadData[8] : 1'b1,
                                         loadData[7:0], 1'b0};
                        bitsLeft_reg <= nineBit ? ast_pkg::FRAME_BITS_9
                                                : ast_pkg::FRAME_BITS_8;
                        state_reg    <= ast_pkg::SHIFT_SEND;
                    end
                end
                ast_pkg::SHIFT_SEND: begin
                    if (bitTick) begin
                        shift_reg    <= {1'b1, shift_reg[10:1]};
                        bitsLeft_reg <= bitsLeft_reg - 1'b1;
                        if (bitsLeft_reg == 4'h1) begin
                            state_reg <= ast_pkg::SHIFT_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ast_pkg::SHIFT_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> logic/ast_async_serial_transmitter.sv
// Asynchronous serial transmitter with AXI4-Lite register access
//
// Notes on behaviour
// - Line is NRZ and rests at mark between characters.
// - Frame: one start at space, eight or nine data, stop at mark.
// - Every bit stays one bit period on the line; a stop bit with a character waiting stays one clock longer.
// - Bit timing comes from a divider working as 8-bit or 16-bit.
// - Data bits leave least significant bit first.
// - Transmitter runs alone but shares format and rate with receiver.
// - No hardware parity; software supplies it as the ninth bit.
// - Shift register unreachable by software; loads only from holding buffer.
// - Sending needs transmit enable 1, synchronous select 0, port enable 1.
// - Port enable alone turns the transmit pin into a driven output.
// - Buffer-empty flag sets as soon as transmit enable is set.
// - Buffer write starts sending; an idle shifter takes it at once.
// - A waiting character moves over right after the previous stop bit.
// - Start, data and stop follow at once after each transfer.
// - Polarity bit resets to 0; 1 inverts idle level and data.
// - Polarity affects transmit data in asynchronous mode only.
// - Flag set unless shifter busy and another character waits.
// - Flag valid from the second cycle after a buffer write.
// - Flag is read-only; software cannot set or clear it.
// - Separate enable gates the request; flag shows emptiness regardless.
// - Port enable 0 holds the whole transmitter in reset.
`timescale 1ns/1ps
`default_nettype none
module ast_async_serial_transmitter #(
    parameter int unsigned DIV_WIDTH  = 16,
    parameter int unsigned ADDR_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // AXI4-Lite write address
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Transmit pin
    output logic                       txPinOut,
    output logic                       txPinOe,
    // Buffer-empty request
    output logic                       txIrqRequest
);
    localparam int unsigned OW = ast_pkg::OFF_W;

    // Parameter check
    generate
        if (ADDR_WIDTH < OW + 1 || ADDR_WIDTH > 32 || DIV_WIDTH != 16) begin : g_bad
            $error("ast_async_serial_transmitter: unsupported parameters");
        end
    endgenerate

    // Software state
    ast_pkg::ast_ctrl_t    ctrl_reg;
    ast_pkg::ast_ctrl_t    ctrl_next;
    logic [DIV_WIDTH-1:0]  div_reg;
    logic [DIV_WIDTH-1:0]  div_next;
    logic [8:0]            holdData_reg;
    logic [8:0]            holdData_next;
    logic                  holdFull_reg;
    logic                  holdFull_next;
    logic                  emptyFlag_reg;
    logic                  emptyFlag_next;
    logic                  txPin_reg;
    logic                  txPin_next;
    logic                  txOe_reg;
    logic                  irq_reg;

    // Bus state
    logic [ADDR_WIDTH-1:0] awAddr_reg;
    logic                  awHeld_reg;
    logic [31:0]           wData_reg;
    logic [3:0]            wStrb_reg;
    logic                  wHeld_reg;
    logic                  bValid_reg;
    logic [1:0]            bResp_reg;
    logic                  rValid_reg;
    logic [1:0]            rResp_reg;
    logic [31:0]           rData_reg;

    // Transmit path
    logic                  portOn;
    logic                  txActive;
    logic                  shiftBusy;
    logic                  lineBit;
    logic                  bitTick;
    logic                  loadShift;
    logic                  polarityUsed;

    // Enable conditions
    assign portOn   = ctrl_reg.serialPortEnable;
    assign txActive = portOn && ctrl_reg.txEnable && !ctrl_reg.syncSelect;

    // Transfer from holding buffer to shifter
    assign loadShift = txActive && holdFull_reg && !shiftBusy;

    // Write channel handshakes
    logic awTake;
    logic wTake;
    logic wrFire;
    assign awTake        = s_axi_awvalid && s_axi_awready;
    assign wTake         = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready  = !wHeld_reg && !bValid_reg;
    assign wrFire        = awHeld_reg && wHeld_reg && !bValid_reg;

    // Write decode
    logic             wrUpperZero;
    logic [OW-1:0]    wrOff;
    logic             wrTx;
    logic             wrRx;
    logic             wrBaud;
    logic             wrDiv;
    logic             wrHold;
    logic             wrFlags;
    logic             wrIrqEn;
    logic             wrHit;
    logic             lane0;
    logic             lane1;
    logic             wrOk;
    assign wrUpperZero = (awAddr_reg[ADDR_WIDTH-1:OW] == '0);
    assign wrOff       = awAddr_reg[OW-1:0];
    assign wrOk        = wrFire && wrUpperZero;
    assign wrTx        = wrOk && (wrOff == ast_pkg::OFF_TX_CTRL);
    assign wrRx        = wrOk && (wrOff == ast_pkg::OFF_RX_CTRL);
    assign wrBaud      = wrOk && (wrOff == ast_pkg::OFF_BAUD_CTRL);
    assign wrDiv       = wrOk && (wrOff == ast_pkg::OFF_BAUD_DIV);
    assign wrHold      = wrOk && (wrOff == ast_pkg::OFF_TX_HOLD);
    assign wrFlags     = wrOk && (wrOff == ast_pkg::OFF_IRQ_FLAGS);
    assign wrIrqEn     = wrOk && (wrOff == ast_pkg::OFF_IRQ_ENABLE);
    assign wrHit       = wrTx || wrRx || wrBaud || wrDiv || wrHold || wrFlags || wrIrqEn;
    assign lane0       = wStrb_reg[0];
    assign lane1       = wStrb_reg[1];

    // Control register updates
    always_comb begin
        ctrl_next = ctrl_reg;
        div_next  = div_reg;
        if (wrTx && lane0) begin
            ctrl_next.txEnable   = wData_reg[ast_pkg::POS_TX_ENABLE];
            ctrl_next.syncSelect = wData_reg[ast_pkg::POS_SYNC_SEL];
            ctrl_next.nineBit    = wData_reg[ast_pkg::POS_NINE_BIT];
            ctrl_next.ninthData  = wData_reg[ast_pkg::POS_NINTH_DATA];
        end
        if (wrRx && lane0) ctrl_next.serialPortEnable = wData_reg[ast_pkg::POS_PORT_EN];
        if (wrBaud && lane0) begin
            ctrl_next.polarity = wData_reg[ast_pkg::POS_POLARITY];
            ctrl_next.brg16    = wData_reg[ast_pkg::POS_BRG16];
        end
        if (wrIrqEn && lane0) ctrl_next.irqEnable = wData_reg[ast_pkg::POS_IRQ_EN];
        if (wrDiv && lane0) div_next[7:0] = wData_reg[7:0];
        if (wrDiv && lane1) div_next[15:8] = wData_reg[15:8];
    end

    // Holding buffer; a new write replaces a waiting character
    always_comb begin
        holdData_next = holdData_reg;
        holdFull_next = holdFull_reg;
        if (!txActive) begin
            holdFull_next = 1'b0;
        end else if (wrHold && lane0) begin
            holdData_next = {ctrl_reg.ninthData, wData_reg[7:0]};
            holdFull_next = 1'b1;
        end else if (loadShift) begin
            holdFull_next = 1'b0;
        end
    end

    // Buffer-empty flag follows enable, shifter and buffer state only
    assign emptyFlag_next = txActive && !(shiftBusy && holdFull_reg);

    // Pin level; polarity only in asynchronous mode
    assign polarityUsed = ctrl_reg.polarity && !ctrl_reg.syncSelect;
    assign txPin_next   = portOn ? (lineBit ^ polarityUsed) : 1'b1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg      <= ast_pkg::CTRL_RESET;
            div_reg       <= ast_pkg::DIV_RESET;
            holdData_reg  <= ast_pkg::HOLD_RESET;
            holdFull_reg  <= 1'b0;
            emptyFlag_reg <= 1'b0;
            txPin_reg     <= 1'b1;
            txOe_reg      <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            div_reg       <= div_next;
            holdData_reg  <= holdData_next;
            holdFull_reg  <= holdFull_next;
            emptyFlag_reg <= emptyFlag_next;
            txPin_reg     <= txPin_next;
            txOe_reg      <= portOn;
            irq_reg       <= emptyFlag_reg && ctrl_reg.irqEnable;
        end
    end

    // Bit timing, restarted at each frame
    ast_baud_gen #(
        .DIV_WIDTH (DIV_WIDTH)
    ) u_baud (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .restart   (loadShift || !txActive),
        .brg16     (ctrl_reg.brg16),
        .divisor   (div_reg),
        .bitTick   (bitTick)
    );

    // Shift register; cleared whenever the transmitter is off
    ast_tx_shifter u_shift (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clear     (!txActive),
        .load      (loadShift),
        .loadData  (holdData_reg),
        .nineBit   (ctrl_reg.nineBit),
        .bitTick   (bitTick),
        .lineBit   (lineBit),
        .busy      (shiftBusy)
    );

    // Write channel capture and response
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awAddr_reg <= '0;
            awHeld_reg <= 1'b0;
            wData_reg  <= 32'h0000_0000;
            wStrb_reg  <= 4'h0;
            wHeld_reg  <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg  <= ast_pkg::RESP_OKAY;
        end else begin
            if (awTake) begin
                awAddr_reg <= s_axi_awaddr;
                awHeld_reg <= 1'b1;
            end
            if (wTake) begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
                wHeld_reg <= 1'b1;
            end
            if (wrFire) begin
                awHeld_reg <= 1'b0;
                wHeld_reg  <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg  <= wrHit ? ast_pkg::RESP_OKAY : ast_pkg::RESP_SLVERR;
            end else if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    // Read decode
    logic          arTake;
    logic          rdUpperZero;
    logic [OW-1:0] rdOff;
    logic [31:0]   rdTx;
    logic [31:0]   rdRx;
    logic [31:0]   rdBaud;
    logic [31:0]   rdFlags;
    logic [31:0]   rdIrqEn;
    logic [31:0]   rdMux;
    logic          rdHit;
    assign arTake        = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rValid_reg;
    assign rdUpperZero   = (s_axi_araddr[ADDR_WIDTH-1:OW] == '0);
    assign rdOff         = s_axi_araddr[OW-1:0];
    assign rdTx    = (32'(ctrl_reg.txEnable)   << ast_pkg::POS_TX_ENABLE)
                   | (32'(ctrl_reg.syncSelect) << ast_pkg::POS_SYNC_SEL)
                   | (32'(ctrl_reg.nineBit)    << ast_pkg::POS_NINE_BIT)
                   | (32'(ctrl_reg.ninthData)  << ast_pkg::POS_NINTH_DATA)
                   | (32'(!shiftBusy)          << ast_pkg::POS_SHIFT_EMPT);
    assign rdRx    = 32'(ctrl_reg.serialPortEnable) << ast_pkg::POS_PORT_EN;
    assign rdBaud  = (32'(ctrl_reg.polarity) << ast_pkg::POS_POLARITY)
                   | (32'(ctrl_reg.brg16)    << ast_pkg::POS_BRG16);
    assign rdFlags = 32'(emptyFlag_reg) << ast_pkg::POS_EMPTY_FLAG;
    assign rdIrqEn = 32'(ctrl_reg.irqEnable) << ast_pkg::POS_IRQ_EN;

    // Holding buffer reads as zero; shift register has no address
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = rdUpperZero;
        case (rdOff)
            ast_pkg::OFF_TX_CTRL: rdMux = rdTx;
            ast_pkg::OFF_RX_CTRL: rdMux = rdRx;
            ast_pkg::OFF_BAUD_CTRL: rdMux = rdBaud;
            ast_pkg::OFF_BAUD_DIV: rdMux = 32'(div_reg);
            ast_pkg::OFF_TX_HOLD: rdMux = 32'h0000_0000;
            ast_pkg::OFF_IRQ_FLAGS: rdMux = rdFlags;
            ast_pkg::OFF_IRQ_ENABLE: rdMux = rdIrqEn;
            default: rdHit = 1'b0;
        endcase
        if (!rdUpperZero) begin
            rdMux = 32'h0000_0000;
        end
    end

    // Read channel
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rValid_reg <= 1'b0;
            rResp_reg  <= ast_pkg::RESP_OKAY;
            rData_reg  <= 32'h0000_0000;
        end else if (arTake) begin
            rValid_reg <= 1'b1;
            rResp_reg  <= rdHit ? ast_pkg::RESP_OKAY : ast_pkg::RESP_SLVERR;
            rData_reg  <= rdHit ? rdMux : 32'h0000_0000;
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // Outputs
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp  = bResp_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rresp  = rResp_reg;
    assign s_axi_rdata  = rData_reg;
    assign txPinOut     = txPin_reg;
    assign txPinOe      = txOe_reg;
    assign txIrqRequest = irq_reg;
endmodule
`default_nettype wire

// >>> verification/ast_tx_asserts.sv
// Port checks for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module ast_tx_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line and request
    input wire logic txPinOut,
    input wire logic txPinOe,
    input wire logic txIrqRequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    reset_state_a: assert property (disable iff (1'b0)
        $past(sys_rst) |-> txPinOut && !txPinOe && !txIrqRequest) else $error("reset level");
    port_off_a: assert property (!txPinOe |-> txPinOut) else $error("line not mark");
    start_oe_a: assert property ($fell(txPinOut) |-> txPinOe) else $error("edge while off");
    irq_oe_a: assert property ($rose(txIrqRequest) |-> txPinOe) else $error("irq while off");
    bvalid_hold_a: assert property (s_axi_bvalid |=> s_axi_bvalid == !$past(s_axi_bready))
        else $error("bvalid drop");
    rvalid_hold_a: assert property (s_axi_rvalid |=> s_axi_rvalid == !$past(s_axi_rready))
        else $error("rvalid drop");
    write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken");
    read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule
bind ast_async_serial_transmitter ast_tx_asserts i_chk (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .txIrqRequest(txIrqRequest));
`default_nettype wire

// >>> verification/ast_rx_model.sv
// Remote receiver model on the transmit line
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model (
    // Clock
    input  wire logic        clk,
    // Line and format
    input  wire logic        line,
    input  wire logic        en,
    input  wire logic        inv,
    input  wire logic        nine,
    input  wire logic [15:0] bitLen,
    // Received characters
    output logic      [8:0]  rxData,
    output int               rxCount,
    output int               frameErrs
);
    initial begin
        logic [8:0] d;
        rxData = '0;
        rxCount = 0;
        frameErrs = 0;
        forever begin
            @(posedge clk);
            if (en && (line ^ inv) === 1'b0) begin
                d = '0;
                repeat (bitLen / 2) @(posedge clk);
                if ((line ^ inv) !== 1'b0) frameErrs++;
                for (int i = 0; i < (nine ? 9 : 8); i++) begin
                    repeat (bitLen) @(posedge clk);
                    d[i] = line ^ inv;
                end
                repeat (bitLen) @(posedge clk);
                if ((line ^ inv) !== 1'b1) frameErrs++;
                rxData = d;
                rxCount++;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, txOut, txOe, txIrq, rxEn, pol, nine;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] bitLen;
    logic [8:0]  rxData;
    int          rxCount, frameErrs, error_cnt, n_compared, len;
    ast_async_serial_transmitter i_dut (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .txPinOut(txOut), .txPinOe(txOe), .txIrqRequest(txIrq));
    ast_rx_model i_rx (.clk(clk), .line(txOut), .en(rxEn), .inv(pol), .nine(nine),
        .bitLen(bitLen), .rxData(rxData), .rxCount(rxCount), .frameErrs(frameErrs));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr  <= {3'b000, a};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            awvalid <= awvalid && !awready;
            wvalid  <= wvalid && !wready;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task rdr(input logic [4:0] a);
        @(posedge clk);
        araddr  <= {3'b000, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            arvalid <= arvalid && !arready;
        end while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task chkReg(input logic [4:0] a, input logic [31:0] exp);
        rdr(a);
        chk(rd, exp);
    endtask
    task waitRx(input int n);
        for (int k = 0; k < 4000 && rxCount < n; k++) @(posedge clk);
        chk(rxCount, n);
    endtask
    task measure();
        len = 0;
        while ((txOut ^ pol) !== 1'b0) @(posedge clk);
        while ((txOut ^ pol) === 1'b0) begin
            @(posedge clk);
            len++;
        end
    endtask
    task wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, rxEn, pol, nine} = '0;
        {awaddr, araddr, wdata} = '0;
        {error_cnt, n_compared} = '0;
        bitLen = 16'h0004;
        sys_rst = 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(txOut, 1'b1);
        chk(txOe, 1'b0);
        chkReg(ast_pkg::OFF_BAUD_CTRL, 32'h0000_0000);
        wr(ast_pkg::OFF_BAUD_DIV, 32'h0000_0103);
        wr(ast_pkg::OFF_RX_CTRL, 32'h0000_0080);
        repeat (2) @(posedge clk);
        chk(txOe, 1'b1);
        rxEn = 1'b1;
        wr(ast_pkg::OFF_TX_HOLD, 32'h0000_0041);
        chkReg(ast_pkg::OFF_IRQ_FLAGS, 32'h0000_0000);
        wr(ast_pkg::OFF_TX_CTRL, 32'h0000_0001);
        chkReg(ast_pkg::OFF_IRQ_FLAGS, 32'h0000_0001);
        wr(ast_pkg::OFF_IRQ_FLAGS, 32'h0000_0000);
        chkReg(ast_pkg::OFF_IRQ_FLAGS, 32'h0000_0001);
        chk(txIrq, 1'b0);
        wr(ast_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(txIrq, 1'b1);
        chk(rxCount, 0);
        fork
            measure();
            wr(ast_pkg::OFF_TX_HOLD, 32'h0000_0001);
        join
        chk(len, 4);
        waitRx(1);
        chk(rxData, 9'h001);
        wr(ast_pkg::OFF_TX_HOLD, 32'h0000_00A5);
        wr(ast_pkg::OFF_TX_HOLD, 32'h0000_003C);
        repeat (2) @(posedge clk);
        chkReg(ast_pkg::OFF_IRQ_FLAGS, 32'h0000_0000);
        chk(txIrq, 1'b0);
        waitRx(2);
        chk(rxData, 9'h0A5);
        waitRx(3);
        chk(rxData, 9'h03C);
        chkReg(ast_pkg::OFF_IRQ_FLAGS, 32'h0000_0001);
        wr(ast_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
        nine = 1'b1;
        wr(ast_pkg::OFF_TX_CTRL, 32'h0000_000D);
        wr(ast_pkg::OFF_TX_HOLD, 32'h0000_005A);
        waitRx(4);
        chk(rxData, 9'h15A);
        repeat (8) @(posedge clk);
        nine = 1'b0;
        wr(ast_pkg::OFF_TX_CTRL, 32'h0000_0001);
        rxEn = 1'b0;
        wr(ast_pkg::OFF_BAUD_CTRL, 32'h0000_0010);
        repeat (3) @(posedge clk);
        chk(txOut, 1'b0);
        pol = 1'b1;
        rxEn = 1'b1;
        wr(ast_pkg::OFF_TX_HOLD, 32'h0000_0033);
        waitRx(5);
        chk(rxData, 9'h033);
        repeat (10) @(posedge clk);
        rxEn = 1'b0;
        wr(ast_pkg::OFF_BAUD_CTRL, 32'h0000_0008);
        repeat (3) @(posedge clk);
        pol = 1'b0;
        bitLen = 16'h0104;
        rxEn = 1'b1;
        fork
            measure();
            wr(ast_pkg::OFF_TX_HOLD, 32'h0000_0001);
        join
        chk(len, 260);
        waitRx(6);
        chk(rxData, 9'h001);
        wr(5'h1C, 32'h0000_0001);
        chk(rsp, ast_pkg::RESP_SLVERR);
        chkReg(5'h1C, 32'h0000_0000);
        chk(rsp, ast_pkg::RESP_SLVERR);
        wr(ast_pkg::OFF_TX_CTRL, 32'h0000_0003);
        chkReg(ast_pkg::OFF_IRQ_FLAGS, 32'h0000_0000);
        wr(ast_pkg::OFF_RX_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk(txOe, 1'b0);
        chk(txOut, 1'b1);
        chk(frameErrs, 0);
        wrap_up();
    end
endmodule
`default_nettype wire
